/* verilog/mode1_cfg_params.svh */
// Offsets, field positions, reset values and timing counts of the bank
`ifndef MODE1_CFG_PARAMS_SVH
`define MODE1_CFG_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_EDGE_SYS_BUCK   8'h27
`define OFS_AON_ENABLES     8'h28
`define OFS_WDOG_SYS_REG    8'h29

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_EDGE_SYS_BUCK   8'h4C
`define RST_AON_ENABLES     8'h4F
`define RST_WDOG_SYS_REG    8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define POS_RSVD            7
`define POS_EDGE_POLICY     6
`define POS_OFFSET          5
`define POS_CORE_BUCK_ON    3
`define POS_SYS_BUCK_ON     2
`define POS_AON_ON          1
`define POS_SYS_REG_ON      0

// ****************************************************************
// Code limits (5-bit and 4-bit voltage codes)
// ****************************************************************
`define MAX_CODE5           5'h18
`define MAX_CODE4           4'h8
`define OFFSET_STEPS        6'h30

// ****************************************************************
// Watchdog periods in seconds
// ****************************************************************
`define WDOG_16_S           7'h10
`define WDOG_32_S           7'h20
`define WDOG_64_S           7'h40

`endif

/* verilog/mode1_cfg_pkg.sv */
// Types shared by the mode setting 1 configuration bank
package mode1_cfg_pkg;

    typedef enum logic [1:0] {
        MODE_S0 = 2'b00,
        MODE_S1 = 2'b01,
        MODE_S2 = 2'b10,
        MODE_S3 = 2'b11
    } mode_e;

    typedef struct packed {
        logic       write_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic       core_buck_on;
        logic       sys_buck_on;
        logic       aon_regulator_on;
        logic       sys_regulator_on;
        logic [5:0] sys_buck_steps;
        logic [3:0] aon_regulator_steps;
        logic [5:0] sys_regulator_steps;
        logic [6:0] watchdog_seconds;
    } rail_cfg_s;

    typedef struct packed {
        logic [7:0] edge_sys_buck;
        logic [7:0] aon_enables;
        logic [7:0] wdog_sys_reg;
    } bank_s;

endpackage

/* verilog/mode1_reg_store.sv */
// Three-byte register store with a registered read port
module mode1_reg_store
    import mode1_cfg_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire mode1_cfg_pkg::reg_req_s req,
    output logic [7:0]                rdata,
    output mode1_cfg_pkg::bank_s      bank
);
    `include "mode1_cfg_params.svh"

    typedef struct packed {
        bank_s      bank;
        logic [7:0] rdata;
    } store_s;

    store_s st_reg;
    store_s st_next;

    always_comb
    begin
        st_next = st_reg;
        // Every bit, the reserved one included, is stored as written
        if (req.write_en)
        begin
            if (req.addr == `OFS_EDGE_SYS_BUCK)
                st_next.bank.edge_sys_buck = req.wdata;
            else if (req.addr == `OFS_AON_ENABLES)
                st_next.bank.aon_enables = req.wdata;
            else if (req.addr == `OFS_WDOG_SYS_REG)
                st_next.bank.wdog_sys_reg = req.wdata;
        end
        // Unmapped offsets read as zero
        if (req.addr == `OFS_EDGE_SYS_BUCK)
            st_next.rdata = st_reg.bank.edge_sys_buck;
        else if (req.addr == `OFS_AON_ENABLES)
            st_next.rdata = st_reg.bank.aon_enables;
        else if (req.addr == `OFS_WDOG_SYS_REG)
            st_next.rdata = st_reg.bank.wdog_sys_reg;
        else
            st_next.rdata = 8'h00;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg.bank.edge_sys_buck <= `RST_EDGE_SYS_BUCK;
            st_reg.bank.aon_enables   <= `RST_AON_ENABLES;
            st_reg.bank.wdog_sys_reg  <= `RST_WDOG_SYS_REG;
            st_reg.rdata              <= 8'h00;
        end
        else if (clk_en)
            st_reg <= st_next;
    end

    assign rdata = st_reg.rdata;
    assign bank  = st_reg.bank;

    a_write_readback: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && req.write_en && req.addr == `OFS_AON_ENABLES
        |=> bank.aon_enables == $past(req.wdata))
        else $error("register write not stored");
endmodule

/* verilog/mode1_config_bank.sv */
// Mode setting 1 configuration bank: registers, mode choice, rail outputs
//
// Behaviour
// - With edge policy 0 a valid ON falling edge in mode 1 returns the mode to 0.
// - With edge policy 1 a valid ON falling edge changes no mode.
// - System buck target is its code plus 1.2 V when the offset bit is 1.
// - System buck code runs 1.500 V to 2.100 V in 25 mV steps, clamped.
// - Always-on code runs 1.700 V to 1.900 V in 25 mV steps, clamped.
// - Bit 3 of the enable register switches the core buck in mode 1.
// - Bit 2 of the enable register switches the system buck in mode 1.
// - Bit 1 of the enable register switches the always-on rail in mode 1.
// - Enable bit 0 switches the system regulator in mode 1.
// - Watchdog field selects off, 16 s, 32 s or 64 s, resetting to off.
// - System regulator target is its code plus 1.2 V when offset is 1.
// - System regulator code runs 1.500 V to 2.100 V, clamped above.
// - All three registers read back every written bit, reserved included.
// - Pin mode select uses only the pins, else only the register bits.
module mode1_config_bank
(
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    input  wire mode1_cfg_pkg::reg_req_s   req,
    output logic [7:0]                     rdata,
    input  wire logic                      on_fall_valid,
    input  wire logic                      mode_sel_by_pin,
    input  wire logic                      mode_select_pin_a,
    input  wire logic                      mode_select_pin_b,
    input  wire logic                      mode_reg_bit_a,
    input  wire logic                      mode_reg_bit_b,
    output mode1_cfg_pkg::mode_e           active_mode,
    output logic                           mode1_active,
    output mode1_cfg_pkg::rail_cfg_s       rail_cfg
);
    import mode1_cfg_pkg::*;
    `include "mode1_cfg_params.svh"

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Codes above the top step all select the top voltage
    function automatic logic [5:0] steps5(input logic [4:0] code,
                                          input logic       offset);
        logic [4:0] c;
        c = (code > `MAX_CODE5) ? `MAX_CODE5 : code;
        steps5 = {1'b0, c} + (offset ? `OFFSET_STEPS : 6'h00);
    endfunction

    function automatic logic [6:0] wdog_secs(input logic [1:0] sel);
        case (sel)
            2'b01:   wdog_secs = `WDOG_16_S;
            2'b10:   wdog_secs = `WDOG_32_S;
            2'b11:   wdog_secs = `WDOG_64_S;
            default: wdog_secs = 7'h00;
        endcase
    endfunction

    // ****************************************************************
    // Register store
    // ****************************************************************
    bank_s bank;

    mode1_reg_store u_store
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .req    (req),
        .rdata  (rdata),
        .bank   (bank)
    );

    // ****************************************************************
    // Mode tracking
    // ****************************************************************
    typedef struct packed {
        mode_e     mode;
        logic      edge_return;
        rail_cfg_s rail;
    } state_s;

    state_s st_reg;
    state_s st_next;
    mode_e  requested;
    logic   edge_policy;
    // The forced return to mode 0 is held until the requested mode changes,
    // otherwise the request bits would undo it on the very next cycle
    mode_e  req_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            req_q <= MODE_S0;
        else if (clk_en)
            req_q <= requested;
    end

    always_comb
    begin
        // Pins and register bits are never mixed
        if (mode_sel_by_pin)
            requested = mode_e'({mode_select_pin_b, mode_select_pin_a});
        else
            requested = mode_e'({mode_reg_bit_b, mode_reg_bit_a});
        edge_policy = bank.edge_sys_buck[`POS_EDGE_POLICY];
    end

    always_comb
    begin
        st_next = st_reg;
        if (requested != req_q)
            st_next.edge_return = 1'b0;
        // The edge policy only counts while mode 1 is in force
        if (on_fall_valid && st_reg.mode == MODE_S1 && !edge_policy)
            st_next.edge_return = 1'b1;
        // Policy 1: the edge leaves the mode alone
        case (st_next.edge_return)
            1'b1:    st_next.mode = MODE_S0;
            default: st_next.mode = requested;
        endcase
        st_next.rail = '0;
        if (st_reg.mode == MODE_S1)
        begin
            st_next.rail.core_buck_on =
                bank.aon_enables[`POS_CORE_BUCK_ON];
            st_next.rail.sys_buck_on =
                bank.aon_enables[`POS_SYS_BUCK_ON];
            st_next.rail.aon_regulator_on =
                bank.aon_enables[`POS_AON_ON];
            st_next.rail.sys_regulator_on =
                bank.aon_enables[`POS_SYS_REG_ON];
            st_next.rail.sys_buck_steps = steps5(bank.edge_sys_buck[4:0],
                bank.edge_sys_buck[`POS_OFFSET]);
            st_next.rail.aon_regulator_steps =
                (bank.aon_enables[7:4] > `MAX_CODE4) ? `MAX_CODE4
                : bank.aon_enables[7:4];
            st_next.rail.sys_regulator_steps = steps5(bank.wdog_sys_reg[4:0],
                bank.wdog_sys_reg[`POS_OFFSET]);
            st_next.rail.watchdog_seconds =
                wdog_secs(bank.wdog_sys_reg[7:6]);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg.mode        <= MODE_S0;
            st_reg.edge_return <= 1'b0;
            st_reg.rail        <= '0;
        end
        else if (clk_en)
            st_reg <= st_next;
    end

    assign active_mode  = st_reg.mode;
    assign mode1_active = (st_reg.mode == MODE_S1);
    assign rail_cfg     = st_reg.rail;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_edge_returns: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && on_fall_valid && active_mode == MODE_S1 && !edge_policy
        |=> active_mode == MODE_S0)
        else $error("edge did not return to mode 0");

    a_return_held: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && st_reg.edge_return && requested == req_q
        |=> active_mode == MODE_S0)
        else $error("forced mode 0 not held");

    a_edge_ignored: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && active_mode == MODE_S1 && edge_policy && !st_reg.edge_return
        && requested == MODE_S1 |=> active_mode == MODE_S1)
        else $error("edge changed mode under policy 1");

    a_policy1_edge: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && on_fall_valid && mode1_active && edge_policy
        && !st_reg.edge_return |=> active_mode == $past(requested))
        else $error("policy 1 edge forced a mode change");

    a_edge_outside: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && on_fall_valid && !mode1_active && !st_reg.edge_return
        |=> !st_reg.edge_return)
        else $error("edge acted outside mode 1");

    a_buck_target: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.edge_sys_buck[4:0] == 5'h1F
        && bank.edge_sys_buck[`POS_OFFSET]
        |=> rail_cfg.sys_buck_steps == 6'h48)
        else $error("buck offset target wrong");

    a_buck_offset: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.edge_sys_buck[`POS_OFFSET]
        && bank.edge_sys_buck[4:0] <= 5'h18
        |=> rail_cfg.sys_buck_steps
            == {1'b0, $past(bank.edge_sys_buck[4:0])} + 6'h30)
        else $error("buck offset not added");

    a_buck_clamp: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && !bank.edge_sys_buck[`POS_OFFSET]
        |=> rail_cfg.sys_buck_steps <= 6'h18)
        else $error("buck code not clamped");

    a_buck_map: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && !bank.edge_sys_buck[`POS_OFFSET]
        && bank.edge_sys_buck[4:0] <= 5'h18
        |=> rail_cfg.sys_buck_steps == {1'b0, $past(bank.edge_sys_buck[4:0])})
        else $error("buck code mapped wrong");

    a_aon_clamp: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active
        |=> rail_cfg.aon_regulator_steps <= 4'h8)
        else $error("always-on code not clamped");

    a_aon_top: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.aon_enables[7:4] > 4'h8
        |=> rail_cfg.aon_regulator_steps == 4'h8)
        else $error("always-on top code wrong");

    a_aon_map: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.aon_enables[7:4] <= 4'h8
        |=> rail_cfg.aon_regulator_steps == $past(bank.aon_enables[7:4]))
        else $error("always-on code mapped wrong");

    a_core_enable: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active
        |=> rail_cfg.core_buck_on == $past(bank.aon_enables[3]))
        else $error("core buck enable wrong");

    a_sys_buck_en: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active
        |=> rail_cfg.sys_buck_on == $past(bank.aon_enables[2]))
        else $error("system buck enable wrong");

    a_aon_enable: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active
        |=> rail_cfg.aon_regulator_on == $past(bank.aon_enables[1]))
        else $error("always-on enable wrong");

    a_sysreg_enable: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active
        |=> rail_cfg.sys_regulator_on == $past(bank.aon_enables[0]))
        else $error("system regulator enable wrong");

    a_wdog_off: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.wdog_sys_reg[7:6] == 2'b00
        |=> rail_cfg.watchdog_seconds == 7'h00)
        else $error("watchdog not disabled");

    a_wdog_short: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.wdog_sys_reg[7:6] == 2'b01
        |=> rail_cfg.watchdog_seconds == 7'h10)
        else $error("watchdog short period wrong");

    a_wdog_period: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.wdog_sys_reg[7:6] == 2'b10
        |=> rail_cfg.watchdog_seconds == 7'h20)
        else $error("watchdog period wrong");

    a_wdog_long: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.wdog_sys_reg[7:6] == 2'b11
        |=> rail_cfg.watchdog_seconds == 7'h40)
        else $error("watchdog long period wrong");

    a_sysreg_clamp: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.wdog_sys_reg[4:0] == 5'h1B
        && !bank.wdog_sys_reg[`POS_OFFSET]
        |=> rail_cfg.sys_regulator_steps == 6'h18)
        else $error("system regulator target wrong");

    a_sysreg_map: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && !bank.wdog_sys_reg[`POS_OFFSET]
        && bank.wdog_sys_reg[4:0] <= 5'h18
        |=> rail_cfg.sys_regulator_steps == {1'b0, $past(bank.wdog_sys_reg[4:0])})
        else $error("system regulator code mapped wrong");

    a_sysreg_offset: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode1_active && bank.wdog_sys_reg[`POS_OFFSET]
        && bank.wdog_sys_reg[4:0] <= 5'h18
        |=> rail_cfg.sys_regulator_steps
            == {1'b0, $past(bank.wdog_sys_reg[4:0])} + 6'h30)
        else $error("system regulator offset not added");

    a_pin_select: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && mode_sel_by_pin && !st_next.edge_return
        |=> active_mode == mode_e'({$past(mode_select_pin_b),
                                    $past(mode_select_pin_a)}))
        else $error("pin mode select ignored");

    a_reg_select: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && !mode_sel_by_pin && !st_next.edge_return
        |=> active_mode == mode_e'({$past(mode_reg_bit_b),
                                    $past(mode_reg_bit_a)}))
        else $error("register mode select ignored");

    a_freeze_mode: assert property (@(posedge clk)
        disable iff (!rst_n)
        !clk_en |=> $stable(active_mode))
        else $error("mode moved while clock enable low");

    a_freeze_rails: assert property (@(posedge clk)
        disable iff (!rst_n)
        !clk_en |=> $stable(rail_cfg))
        else $error("rails moved while clock enable low");

    a_idle_rails: assert property (@(posedge clk)
        disable iff (!rst_n)
        clk_en && !mode1_active |=> rail_cfg == '0)
        else $error("rails driven outside mode 1");
endmodule

/* dv/host_req_model.sv */
// Host side model that issues single byte register accesses
module host_req_model
    import mode1_cfg_pkg::*;
(
    input  wire logic                    clk,
    output mode1_cfg_pkg::reg_req_s      req,
    input  wire logic [7:0]              rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Access task
    // ************************************************************
    initial req = '{1'b0, 8'hFF, 8'h00};

    // Idle request shows inverted address and data, never a write,
    // so a stale value cannot pass for a held request
    task automatic access(input logic w, input logic [7:0] a, d,
                          output logic [7:0] q);
        req = '{w, a, d};
        @(posedge clk);
        #1;
        q = rdata;
        req = '{1'b0, ~a, ~d};
        @(posedge clk);
        #1;
    endtask
endmodule

/* dv/test_mode1_config_bank.sv */
// Self-checking bench for the mode setting 1 configuration bank
module test_mode1_config_bank;
    timeunit 1ns;
    timeprecision 100ps;
    import mode1_cfg_pkg::*;

    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic          clk;
    logic          rst_n;
    logic          clk_en;
    reg_req_s      req;
    logic [7:0]    rdata;
    logic          on_fall_valid;
    logic          mode_sel_by_pin;
    logic          pin_a;
    logic          pin_b;
    logic          bit_a;
    logic          bit_b;
    mode_e         active_mode;
    logic          mode1_active;
    rail_cfg_s     rail_cfg;
    int            mismatches;
    int            n_compared;
    logic [7:0]    r27 [4];
    logic [7:0]    r28 [4];
    logic [7:0]    r29 [4];
    logic [26:0]   ex [4];

    mode1_config_bank i_dut (
        .clk               (clk),
        .rst_n             (rst_n),
        .clk_en            (clk_en),
        .req               (req),
        .rdata             (rdata),
        .on_fall_valid     (on_fall_valid),
        .mode_sel_by_pin   (mode_sel_by_pin),
        .mode_select_pin_a (pin_a),
        .mode_select_pin_b (pin_b),
        .mode_reg_bit_a    (bit_a),
        .mode_reg_bit_b    (bit_b),
        .active_mode       (active_mode),
        .mode1_active      (mode1_active),
        .rail_cfg          (rail_cfg)
    );

    host_req_model i_host (
        .clk   (clk),
        .req   (req),
        .rdata (rdata)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic cmp_byte(input string n, input logic [7:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_rail(input logic [26:0] e);
        n_compared++;
        if (rail_cfg !== e)
        begin
            mismatches++;
            $display("unexpected rail_cfg: expected %h seen %h", e, rail_cfg);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        i_host.access(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, e);
        logic [7:0] q;
        i_host.access(1'b0, a, 8'h00, q);
        cmp_byte("rdata", e, q);
    endtask

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic pulse_on;
        on_fall_valid = 1'b1;
        step();
        on_fall_valid = 1'b0;
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************************************************
    // Clock, watchdog and tests
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Whole sequence is under a hundred cycles; this leaves wide margin
    initial
    begin
        #40000;
        mismatches++;
        wrap_up();
    end

    initial
    begin
        // Fields: enables, buck steps, aon steps, regulator steps, seconds
        r27 = '{8'h98, 8'h3F, 8'hC0, 8'h61};
        r28 = '{8'h95, 8'h8A, 8'h0F, 8'h70};
        r29 = '{8'h7F, 8'hA0, 8'hD8, 8'h17};
        ex[0] = {4'h5, 6'h18, 4'h8, 6'h48, 7'h10};
        ex[1] = {4'hA, 6'h48, 4'h8, 6'h30, 7'h20};
        ex[2] = {4'hF, 6'h00, 4'h0, 6'h18, 7'h40};
        ex[3] = {4'h0, 6'h31, 4'h7, 6'h17, 7'h00};
        mismatches = 0;
        n_compared = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        on_fall_valid = 1'b0;
        mode_sel_by_pin = 1'b0;
        pin_a = 1'b0;
        pin_b = 1'b1;
        bit_a = 1'b0;
        bit_b = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd_chk(8'h27, 8'h4C);
        rd_chk(8'h28, 8'h4F);
        rd_chk(8'h29, 8'h0C);
        wr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        cmp_rail(27'h0);
        bit_a = 1'b1;
        step();
        cmp_byte("active_mode", 8'h01, {6'h00, active_mode});
        cmp_byte("mode1_active", 8'h01, {7'h00, mode1_active});
        step();
        cmp_rail({4'hF, 6'h0C, 4'h4, 6'h0C, 7'h00});
        mode_sel_by_pin = 1'b1;
        step();
        cmp_byte("active_mode", 8'h02, {6'h00, active_mode});
        pin_a = 1'b1;
        pin_b = 1'b0;
        bit_a = 1'b0;
        step();
        cmp_byte("active_mode", 8'h01, {6'h00, active_mode});
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h27, r27[i]);
            wr(8'h28, r28[i]);
            wr(8'h29, r29[i]);
            rd_chk(8'h27, r27[i]);
            rd_chk(8'h28, r28[i]);
            rd_chk(8'h29, r29[i]);
            cmp_rail(ex[i]);
        end
        pulse_on();
        cmp_byte("active_mode", 8'h01, {6'h00, active_mode});
        wr(8'h27, 8'h21);
        pulse_on();
        cmp_byte("active_mode", 8'h00, {6'h00, active_mode});
        cmp_byte("mode1_active", 8'h00, {7'h00, mode1_active});
        step();
        cmp_rail(27'h0);
        pulse_on();
        cmp_byte("active_mode", 8'h00, {6'h00, active_mode});
        // Changing the requested mode releases the forced return
        pin_b = 1'b1;
        step();
        cmp_byte("active_mode", 8'h03, {6'h00, active_mode});
        pulse_on();
        cmp_byte("active_mode", 8'h03, {6'h00, active_mode});
        mode_sel_by_pin = 1'b0;
        bit_b = 1'b1;
        step();
        cmp_byte("active_mode", 8'h02, {6'h00, active_mode});
        bit_a = 1'b1;
        bit_b = 1'b0;
        step();
        step();
        cmp_rail({4'h0, 6'h31, 4'h7, 6'h17, 7'h00});
        // Frozen clock enable must block the write entirely
        clk_en = 1'b0;
        wr(8'h28, 8'h00);
        clk_en = 1'b1;
        rd_chk(8'h28, 8'h70);
        wrap_up();
    end
endmodule
